// File: src/emsp_pkg.sv
// Constants and types for the exciter mode select and protection block
`default_nettype none
package emsp_pkg;
  // ---
  // Clock and timing base
  // ---
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_MS = TICK_US / 1000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS / TICK_MS;
  localparam int unsigned SAVE_DELAY_MS = 2000;
  localparam logic [13:0] SAVE_TICKS = 14'(SAVE_DELAY_MS / TICK_MS);
  localparam int unsigned OV_LAMP_MS = 5000;
  localparam logic [13:0] OV_LAMP_TICKS = 14'(OV_LAMP_MS / TICK_MS);
  localparam int unsigned ADJ_STEP_MS = 50;
  localparam logic [13:0] ADJ_TICKS = 14'(ADJ_STEP_MS / TICK_MS);
  // Delay settings are in 0.1 s units
  localparam int unsigned DELAY_UNIT_MS = 100;
  localparam logic [13:0] DELAY_UNIT_TICKS = 14'(DELAY_UNIT_MS / TICK_MS);

  // ---
  // Operating modes and contact assignment
  // ---
  typedef enum logic [1:0] {
    EMSP_VREG = 2'b00,
    EMSP_FCR = 2'b01,
    EMSP_VAR = 2'b10,
    EMSP_PF = 2'b11
  } emsp_mode_t;

  typedef enum logic [1:0] {
    EMSP_VL_NONE = 2'b00,
    EMSP_VL_VARPF = 2'b01,
    EMSP_VL_LIMIT = 2'b10
  } emsp_vl_assign_t;

  // ---
  // Setpoint ranges (signed 12 bit) and reset values
  // ---
  // Voltage: 0.1 % of nominal; FIELD_CURRENT_REGULATION: 0.01 Adc; var: 0.1 % (+ generate);
  // PF: hundredths away from unity (+ lag, - lead)
  localparam logic signed [11:0] VREG_MIN = 12'sh2_BC;
  localparam logic signed [11:0] VREG_MAX = 12'sh4_4C;
  localparam logic signed [11:0] VREG_RST = 12'sh3_E8;
  localparam logic signed [11:0] FCR_MIN = 12'sh0_03;
  localparam logic signed [11:0] FCR_MAX = 12'sh2_BC;
  localparam logic signed [11:0] FCR_RST = 12'sh0_64;
  localparam logic signed [11:0] VAR_MIN = -12'sh3_E8;
  localparam logic signed [11:0] VAR_MAX = 12'sh3_E8;
  localparam logic signed [11:0] VAR_RST = 12'sh0_00;
  localparam logic signed [11:0] PF_MIN = -12'sh0_28;
  localparam logic signed [11:0] PF_MAX = 12'sh0_28;
  localparam logic signed [11:0] PF_RST = 12'sh0_00;

  // ---
  // Droop, underfrequency and overvoltage settings
  // ---
  localparam logic [6:0] DROOP_MAX = 7'h64;
  localparam logic [9:0] KNEE_MIN = 10'h1_90;
  localparam logic [9:0] KNEE_MAX = 10'h2_8A;
  localparam logic [9:0] UF_INHIBIT = 10'h0_78;
  localparam logic [8:0] SLOPE_MAX = 9'h1_2C;
  localparam logic [11:0] VFLOOR_NUM = 12'h0_03;
  localparam logic [11:0] VFLOOR_DEN = 12'h0_0A;
  localparam logic [11:0] OV_LVL_MIN = 12'h3_E8;
  localparam logic [11:0] OV_LVL_MAX = 12'h4_B0;
  localparam logic [6:0] OV_DLY_MAX = 7'h64;
  localparam logic [11:0] PER_MILLE = 12'h3_E8;
endpackage
`default_nettype wire

// File: src/emsp_debounce.sv
// Contact synchroniser and tick-based debouncer
`default_nettype none
module emsp_debounce #(
  parameter int unsigned DB_TICKS = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Timing
  input wire logic tick,
  // Contact
  input wire logic raw,
  output logic clean
);
  logic sync1_reg;
  logic sync2_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Output changes only after the new level has held for DB_TICKS ticks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      clean <= 1'b0;
    end else if (sync2_reg == clean) begin
      cnt_reg <= 8'h00;
    end else if (tick) begin
      if (cnt_reg >= 8'(DB_TICKS - 1)) begin
        clean <= sync2_reg;
        cnt_reg <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: src/emsp_top.sv
// Exciter mode decode, setpoint handling and generator overvoltage protection
`default_nettype none
// Notes on behaviour
// RQ1 - Raise/lower adjusts; save after 2 s open
// RQ2 - Contact assigned to var/PF or limiter only
// RQ3 - Var/PF: open enables, closed disables
// RQ4 - Limiter: open overexcitation, closed excitation limiter
// RQ5 - Unassigned contact is ignored entirely; the code still reads it for voltage match
// RQ6 - Parallel contact open enables droop operation
// RQ7 - Var/PF contact has priority over parallel
// RQ8 - Voltage match needs all three contacts closed
// RQ9 - Alarm relay closed normally, opens, non-latching
// RQ10 - Four modes: voltage, field current, var, PF
// RQ11 - Field current setpoint 0.03 to 7 A
// RQ12 - Var span +-100 %; second limiter off
// RQ13 - PF 0.6 lag to lead; limiter off
// RQ14 - Droop by parallel contact, off in var/PF
// RQ15 - Droop up to 10 %, lag lowers voltage
// RQ16 - Below knee follow curve; inhibit under 12 Hz
// RQ17 - Knee 40-65 Hz, slope 0-3, zero disables
// RQ18 - Effective voltage never below 30 % setpoint
// RQ19 - Dwell only after dip below knee
// RQ20 - Overvoltage after delay runs configured action
// RQ21 - After overvoltage shutdown, lamp five seconds
// RQ22 - Overvoltage level 100-120 %, delay 0-10 s
// RQ23 - Var/PF lamp only when enabled and open
// RQ24 - Second-scale delays from fixed tick timers
// RQ25 - Contacts synchronised and debounced before use
module emsp_top #(
  parameter int unsigned TICK_DIV = emsp_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Contacts, 1 = closed
  input wire logic raise_contact,
  input wire logic lower_contact,
  input wire logic var_limiter_contact,
  input wire logic parallel_comp_contact,
  input wire logic voltage_match_contact,
  // Configuration
  input wire emsp_pkg::emsp_mode_t cfg_mode,
  input wire logic cfg_vpf_option,
  input wire emsp_pkg::emsp_vl_assign_t cfg_vl_assign,
  input wire logic cfg_vmatch_enable,
  input wire logic cfg_sp_load,
  input wire logic signed [11:0] cfg_sp_value,
  input wire logic [6:0] cfg_droop,
  input wire logic [9:0] cfg_knee,
  input wire logic [8:0] cfg_slope,
  input wire logic [6:0] cfg_dwell,
  input wire logic [11:0] cfg_ov_level,
  input wire logic [6:0] cfg_ov_delay,
  input wire logic cfg_ov_act_relay,
  input wire logic cfg_ov_act_disable,
  // Measurements and other alarms
  input wire logic [9:0] meas_freq,
  input wire logic signed [11:0] meas_reactive,
  input wire logic [11:0] meas_gen_volt,
  input wire logic ext_alarm,
  input wire logic ov_shutdown_prior,
  // Mode status
  output emsp_pkg::emsp_mode_t mode_active,
  output logic vpf_lamp,
  output logic droop_active,
  output logic vmatch_active,
  output logic limiter_sel_exc,
  output logic exc_limiter_avail,
  output logic second_oel_avail,
  output logic uf_lamp,
  // Setpoints
  output logic [11:0] volt_setpoint_eff,
  output logic signed [11:0] active_setpoint,
  output logic save_strobe,
  output emsp_pkg::emsp_mode_t saved_mode,
  output logic signed [11:0] saved_setpoint,
  // Protection
  output logic ov_lamp,
  output logic ov_shutdown,
  output logic alarm_relay_contact
);
  import emsp_pkg::*;

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  logic [15:0] div_reg;
  logic tick;

  always_ff @(posedge mclk or posedge rst) begin // RQ24
    if (rst) begin
      div_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (div_reg >= 16'(TICK_DIV - 1)) begin
      div_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Contact conditioning
  // ----------------------------------------------------------------
  logic [4:0] raw_c;
  logic [4:0] db_c;
  logic raise_c, lower_c, vl_closed, pc_closed, match_closed;

  assign raw_c = {voltage_match_contact, parallel_comp_contact, var_limiter_contact,
                  lower_contact, raise_contact};
  assign {match_closed, pc_closed, vl_closed, lower_c, raise_c} = db_c;

  for (genvar i = 0; i < 5; i++) begin : g_db
    emsp_debounce #(.DB_TICKS(DEBOUNCE_TICKS)) u_db ( // RQ25
      .mclk(mclk),
      .rst(rst),
      .tick(tick),
      .raw(raw_c[i]),
      .clean(db_c[i])
    );
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic vl_varpf, vl_limit, vpf_cfg, vpf_on;
  emsp_mode_t mode_next;

  assign vl_varpf = (cfg_vl_assign == EMSP_VL_VARPF); // RQ2
  assign vl_limit = (cfg_vl_assign == EMSP_VL_LIMIT); // RQ2
  assign vpf_cfg = cfg_vpf_option && (cfg_mode == EMSP_VAR || cfg_mode == EMSP_PF);
  // Contact state is only looked at for var/PF once an assignment selects it; voltage match reads it always
  assign vpf_on = vpf_cfg && vl_varpf && !vl_closed; // RQ3 RQ5 RQ7

  always_comb begin // RQ10
    if (vpf_on) begin
      mode_next = cfg_mode;
    end else if (cfg_mode == EMSP_FCR) begin
      mode_next = EMSP_FCR;
    end else begin
      mode_next = EMSP_VREG;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_active <= EMSP_VREG;
      vpf_lamp <= 1'b0;
      droop_active <= 1'b0;
      vmatch_active <= 1'b0;
      limiter_sel_exc <= 1'b0;
      exc_limiter_avail <= 1'b0;
      second_oel_avail <= 1'b0;
    end else begin
      mode_active <= mode_next;
      vpf_lamp <= vpf_on; // RQ23
      droop_active <= !pc_closed && !vpf_on && mode_next == EMSP_VREG; // RQ6 RQ14 RQ7
      vmatch_active <= cfg_vmatch_enable && match_closed && vl_closed && pc_closed; // RQ8
      limiter_sel_exc <= vl_limit && vl_closed; // RQ4
      exc_limiter_avail <= !vl_varpf && !(vpf_on && cfg_mode == EMSP_PF); // RQ2 RQ13
      second_oel_avail <= !vl_varpf && !(vpf_on && cfg_mode == EMSP_VAR); // RQ2 RQ12
    end
  end

  // ----------------------------------------------------------------
  // Setpoints per mode with raise/lower
  // ----------------------------------------------------------------
  logic signed [11:0] sp_reg [4];
  logic signed [11:0] sp_cur;
  logic [13:0] adj_cnt_reg;
  logic adjusting;
  logic adj_step;

  function automatic logic signed [11:0] sp_clamp(input emsp_mode_t m,
                                                  input logic signed [12:0] v);
    logic signed [11:0] lo;
    logic signed [11:0] hi;
    lo = VREG_MIN;
    hi = VREG_MAX;
    unique case (m)
      EMSP_VREG: begin lo = VREG_MIN; hi = VREG_MAX; end
      EMSP_FCR: begin lo = FCR_MIN; hi = FCR_MAX; end // RQ11
      EMSP_VAR: begin lo = VAR_MIN; hi = VAR_MAX; end // RQ12
      EMSP_PF: begin lo = PF_MIN; hi = PF_MAX; end // RQ13
    endcase
    if (v < 13'(lo)) begin
      return lo;
    end else if (v > 13'(hi)) begin
      return hi;
    end
    return v[11:0];
  endfunction

  assign sp_cur = sp_reg[mode_next];
  assign adjusting = raise_c ^ lower_c;
  assign adj_step = tick && adjusting && adj_cnt_reg >= ADJ_TICKS - 14'h0001;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adj_cnt_reg <= 14'h0000;
    end else if (!adjusting) begin
      adj_cnt_reg <= 14'h0000;
    end else if (tick) begin
      adj_cnt_reg <= adj_step ? 14'h0000 : adj_cnt_reg + 14'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin // RQ1
    if (rst) begin
      sp_reg[EMSP_VREG] <= VREG_RST;
      sp_reg[EMSP_FCR] <= FCR_RST;
      sp_reg[EMSP_VAR] <= VAR_RST;
      sp_reg[EMSP_PF] <= PF_RST;
    end else if (cfg_sp_load) begin
      sp_reg[cfg_mode] <= sp_clamp(cfg_mode, 13'(cfg_sp_value));
    end else if (adj_step) begin
      sp_reg[mode_next] <= sp_clamp(mode_next, 13'(sp_cur) + (raise_c ? 13'sd1 : -13'sd1));
    end
  end

  // ----------------------------------------------------------------
  // Save after contacts stay open
  // ----------------------------------------------------------------
  logic dirty_reg;
  logic [13:0] open_cnt_reg;

  always_ff @(posedge mclk or posedge rst) begin // RQ1 RQ24
    if (rst) begin
      dirty_reg <= 1'b0;
      open_cnt_reg <= 14'h0000;
      save_strobe <= 1'b0;
      saved_mode <= EMSP_VREG;
      saved_setpoint <= VREG_RST;
    end else begin
      save_strobe <= 1'b0;
      if (raise_c || lower_c) begin
        dirty_reg <= 1'b1;
        open_cnt_reg <= 14'h0000;
      end else if (dirty_reg && tick) begin
        if (open_cnt_reg >= SAVE_TICKS - 14'h0001) begin
          dirty_reg <= 1'b0;
          open_cnt_reg <= 14'h0000;
          save_strobe <= 1'b1;
          saved_mode <= mode_next;
          saved_setpoint <= sp_cur;
        end else begin
          open_cnt_reg <= open_cnt_reg + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Droop and underfrequency shaping of the voltage setpoint
  // ----------------------------------------------------------------
  logic [6:0] droop_c;
  logic [9:0] knee_c;
  logic [8:0] slope_c;
  logic uf_cond;
  logic signed [19:0] droop_prod;
  logic signed [13:0] v_droop;
  logic [21:0] uf_num;
  logic [21:0] uf_red;
  logic [25:0] uf_drop;
  logic [13:0] v_uf;
  logic [11:0] v_floor;
  logic [11:0] v_eff;

  assign droop_c = (cfg_droop > DROOP_MAX) ? DROOP_MAX : cfg_droop; // RQ15
  assign knee_c = (cfg_knee < KNEE_MIN) ? KNEE_MIN : // RQ17
                  (cfg_knee > KNEE_MAX) ? KNEE_MAX : cfg_knee;
  assign slope_c = (cfg_slope > SLOPE_MAX) ? SLOPE_MAX : cfg_slope; // RQ17
  assign uf_cond = mode_next == EMSP_VREG && meas_freq >= UF_INHIBIT && // RQ16
                   meas_freq < knee_c && slope_c != 9'h000; // RQ17

  // Lagging (positive) reactive load pulls the voltage down
  assign droop_prod = 20'(signed'({1'b0, droop_c}) * meas_reactive); // RQ15
  assign v_droop = droop_active ? 14'(sp_reg[EMSP_VREG]) - 14'(droop_prod / 20'sd1000)
                                : 14'(sp_reg[EMSP_VREG]); // RQ14

  // Linear per-unit curve: drop = slope * (knee - f) / knee
  assign uf_num = 22'(slope_c) * 22'(knee_c - meas_freq) * 22'd10;
  assign uf_red = uf_num / 22'(knee_c);
  assign uf_drop = (uf_red > 22'(PER_MILLE)) ? 26'(v_droop[12:0]) :
                   (26'(v_droop[12:0]) * 26'(uf_red[11:0])) / 26'(PER_MILLE);
  assign v_uf = uf_cond ? v_droop - 14'(uf_drop) : v_droop; // RQ16

  // Floor keeps excitation alive on deep speed dips
  assign v_floor = 12'((24'(sp_reg[EMSP_VREG]) * 24'(VFLOOR_NUM)) / 24'(VFLOOR_DEN));
  assign v_eff = (v_uf < 14'(v_floor)) ? v_floor : v_uf[11:0]; // RQ18

  // ----------------------------------------------------------------
  // Dwell after a dip below the knee
  // ----------------------------------------------------------------
  logic dip_reg;
  logic [13:0] dwell_cnt_reg;
  logic [11:0] dwell_hold_reg;

  always_ff @(posedge mclk or posedge rst) begin // RQ19 RQ24
    if (rst) begin
      dip_reg <= 1'b0;
      dwell_cnt_reg <= 14'h0000;
      dwell_hold_reg <= 12'h000;
    end else if (uf_cond) begin
      dip_reg <= 1'b1;
      dwell_cnt_reg <= 14'h0000;
      dwell_hold_reg <= v_eff;
    end else if (dip_reg) begin
      dip_reg <= 1'b0;
      dwell_cnt_reg <= 14'(cfg_dwell) * DELAY_UNIT_TICKS;
    end else if (tick && dwell_cnt_reg != 14'h0000) begin
      dwell_cnt_reg <= dwell_cnt_reg - 14'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      volt_setpoint_eff <= 12'(VREG_RST);
      active_setpoint <= VREG_RST;
      uf_lamp <= 1'b0;
    end else begin
      // Held value only when a recovery follows a real dip, never otherwise
      volt_setpoint_eff <= (!uf_cond && dwell_cnt_reg != 14'h0000) ? dwell_hold_reg
                                                                   : v_eff; // RQ19
      active_setpoint <= sp_cur;
      uf_lamp <= uf_cond; // RQ16
    end
  end

  // ----------------------------------------------------------------
  // Generator overvoltage
  // ----------------------------------------------------------------
  logic [11:0] ov_lvl_c;
  logic [6:0] ov_dly_c;
  logic [13:0] ov_dly_ticks;
  logic [13:0] ov_cnt_reg;
  logic ov_cond;
  logic ov_trip;
  logic boot_reg;
  logic [13:0] lamp_cnt_reg;

  assign ov_lvl_c = (cfg_ov_level < OV_LVL_MIN) ? OV_LVL_MIN : // RQ22
                    (cfg_ov_level > OV_LVL_MAX) ? OV_LVL_MAX : cfg_ov_level;
  assign ov_dly_c = (cfg_ov_delay > OV_DLY_MAX) ? OV_DLY_MAX : cfg_ov_delay; // RQ22
  assign ov_dly_ticks = 14'(ov_dly_c) * DELAY_UNIT_TICKS;
  assign ov_cond = meas_gen_volt > ov_lvl_c;
  assign ov_trip = ov_cond && ov_cnt_reg >= ov_dly_ticks; // RQ20

  // Timer restarts whenever the voltage falls back under the level
  always_ff @(posedge mclk or posedge rst) begin // RQ20 RQ24
    if (rst) begin
      ov_cnt_reg <= 14'h0000;
    end else if (!ov_cond) begin
      ov_cnt_reg <= 14'h0000;
    end else if (tick && ov_cnt_reg < ov_dly_ticks) begin
      ov_cnt_reg <= ov_cnt_reg + 14'h0001;
    end
  end

  // Prior-shutdown mark is caught once, on the first clock after release
  always_ff @(posedge mclk or posedge rst) begin // RQ21
    if (rst) begin
      boot_reg <= 1'b1;
      lamp_cnt_reg <= 14'h0000;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg && ov_shutdown_prior) begin
        lamp_cnt_reg <= OV_LAMP_TICKS;
      end else if (tick && lamp_cnt_reg != 14'h0000) begin
        lamp_cnt_reg <= lamp_cnt_reg - 14'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ov_shutdown <= 1'b0;
      ov_lamp <= 1'b0;
      alarm_relay_contact <= 1'b0;
    end else begin
      if (ov_trip && cfg_ov_act_disable) begin
        ov_shutdown <= 1'b1; // RQ20
      end
      ov_lamp <= (ov_trip && cfg_ov_act_relay) || lamp_cnt_reg != 14'h0000; // RQ20 RQ21
      // Follows its causes; nothing here latches the relay open
      alarm_relay_contact <= !(ov_trip && cfg_ov_act_relay) && !ext_alarm; // RQ9
    end
  end
endmodule
`default_nettype wire

// File: verif/emsp_contact_bank.sv
// Behavioural dry-contact bank feeding the block's contact inputs
`default_nettype none
module emsp_contact_bank (
  // Clock
  input wire logic mclk,
  // Wanted states, 1 = closed
  input wire logic [4:0] want,
  // Contact wiring
  output logic [4:0] contacts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] prev = 5'h00;
  logic [3:0] chatter = 4'h0;
  initial contacts = 5'h00;
  // Real contacts bounce after every change, so the debouncer has work to do
  always @(posedge mclk) begin
    if (want != prev) begin
      prev <= want;
      chatter <= 4'h8;
    end else if (chatter != 4'h0) begin
      chatter <= chatter - 4'h1;
    end
    contacts <= chatter[0] ? ~want : want;
  end
endmodule
`default_nettype wire

// File: verif/emsp_top_properties.sv
// Port-level assertions for the exciter mode select and protection block
`default_nettype none
module emsp_top_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched inputs
  input wire logic cfg_vpf_option,
  input wire logic cfg_vmatch_enable,
  input wire logic [8:0] cfg_slope,
  input wire logic cfg_ov_act_disable,
  input wire logic ext_alarm,
  // Watched outputs
  input wire emsp_pkg::emsp_mode_t mode_active,
  input wire logic vpf_lamp,
  input wire logic droop_active,
  input wire logic vmatch_active,
  input wire logic exc_limiter_avail,
  input wire logic second_oel_avail,
  input wire logic uf_lamp,
  input wire logic signed [11:0] active_setpoint,
  input wire logic save_strobe,
  input wire emsp_pkg::emsp_mode_t saved_mode,
  input wire logic signed [11:0] saved_setpoint,
  input wire logic ov_lamp,
  input wire logic ov_shutdown,
  input wire logic alarm_relay_contact
);
  import emsp_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RELAY_OPEN: assert property (ext_alarm ##1 ext_alarm |-> !alarm_relay_contact)
    else $error("Relay closed during an alarm");
  AST_RELAY_FREE: assert property (!rst && !ext_alarm ##1 (!ext_alarm && !ov_lamp && !ov_shutdown)
    |-> alarm_relay_contact)
    else $error("Relay open with no alarm");
  AST_DROOP_MODE: assert property (droop_active |-> mode_active inside {EMSP_VREG, EMSP_FCR})
    else $error("Droop active in var or pf mode");
  AST_VAR_NO_OEL2: assert property (mode_active == EMSP_VAR |-> !second_oel_avail)
    else $error("Second limiter offered in var mode");
  AST_PF_NO_EXCLIM: assert property (mode_active == EMSP_PF |-> !exc_limiter_avail)
    else $error("Excitation limiter offered in pf mode");
  AST_SAVE_PULSE: assert property (save_strobe |=> !save_strobe)
    else $error("Save strobe longer than one cycle");
  AST_SAVE_VALUE: assert property (save_strobe
    |-> saved_setpoint == active_setpoint && saved_mode == mode_active)
    else $error("Saved value differs from active one");
  AST_OV_LATCH: assert property (ov_shutdown |=> ov_shutdown)
    else $error("Shutdown dropped without reset");
  AST_OV_CAUSE: assert property ($rose(ov_shutdown) |-> $past(cfg_ov_act_disable))
    else $error("Shutdown without disable action");
  AST_VMATCH_EN: assert property (vmatch_active |-> $past(cfg_vmatch_enable))
    else $error("Voltage match while not enabled");
  AST_VPF_OPT: assert property (vpf_lamp |-> $past(cfg_vpf_option))
    else $error("Var pf lamp without option");
  AST_UF_SLOPE: assert property (uf_lamp |-> $past(cfg_slope) != 9'h000)
    else $error("Underfrequency lamp with zero slope");
endmodule
bind emsp_top emsp_top_checker u_chk (.*);
`default_nettype wire

// File: verif/test_emsp_top.sv
// Self-checking bench for the exciter mode select and protection block
`default_nettype none
module test_emsp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import emsp_pkg::*;
  // ---
  // Signals and instances
  // ---
  localparam int unsigned DIV = 4;
  logic mclk, rst, cfg_vpf_option, cfg_vmatch_enable, cfg_sp_load, cfg_ov_act_relay;
  logic cfg_ov_act_disable, ext_alarm, ov_shutdown_prior, vpf_lamp, droop_active;
  logic vmatch_active, limiter_sel_exc, exc_limiter_avail, second_oel_avail, uf_lamp;
  logic save_strobe, ov_lamp, ov_shutdown, alarm_relay_contact;
  logic [4:0] want, contacts;
  emsp_mode_t cfg_mode, mode_active, saved_mode;
  emsp_vl_assign_t cfg_vl_assign;
  logic signed [11:0] cfg_sp_value, meas_reactive, active_setpoint, saved_setpoint;
  logic [6:0] cfg_droop, cfg_dwell, cfg_ov_delay;
  logic [9:0] cfg_knee, meas_freq;
  logic [8:0] cfg_slope;
  logic [11:0] cfg_ov_level, meas_gen_volt, volt_setpoint_eff;
  int miscompares, samples_checked, n;
  // Rows: cfg mode, assignment, var/limiter, parallel, match, mode, droop, lamp, match
  logic [11:0] mrow [8] = '{12'h912, 12'h984, 12'h9E1, 12'hD7A, 12'h448, 12'h4C8, 12'hA40,
    12'h004};
  emsp_mode_t lmode [8] = '{EMSP_VAR, EMSP_VAR, EMSP_PF, EMSP_PF, EMSP_VREG, EMSP_VREG,
    EMSP_FCR, EMSP_FCR};
  logic [11:0] lval [8] = '{12'h7D0, 12'h830, 12'hF9C, 12'h050, 12'h000, 12'h7FF, 12'h001,
    12'h2BA};
  logic [11:0] lexp [8] = '{VAR_MAX, VAR_MIN, PF_MIN, PF_MAX, VREG_MIN, VREG_MAX, FCR_MIN,
    12'h2BA};
  emsp_contact_bank bank (.mclk(mclk), .want(want), .contacts(contacts));
  emsp_top #(.TICK_DIV(DIV)) dut (.*, .raise_contact(contacts[4]),
    .lower_contact(contacts[3]), .var_limiter_contact(contacts[2]),
    .parallel_comp_contact(contacts[1]), .voltage_match_contact(contacts[0]));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ---
  // Tasks
  // ---
  task automatic chk(input logic [15:0] seen, exp);
    #1;
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Covers bounce plus the ten-tick debounce
  task automatic set_contacts(input logic [4:0] w);
    want <= w;
    cyc(70);
  endtask
  task automatic wait_sig(input bit sel_ov, input logic lvl, input int lim, output int t);
    t = 0;
    while ((sel_ov ? ov_lamp : save_strobe) !== lvl) begin
      @(posedge mclk);
      #1;
      t++;
      if (t > lim) begin
        miscompares++;
        give_verdict();
      end
    end
  endtask
  // ---
  // Main sequence
  // ---
  initial begin
    {rst, cfg_vpf_option, cfg_vmatch_enable, cfg_ov_act_relay} = 4'hF;
    {cfg_sp_load, cfg_ov_act_disable, ext_alarm, ov_shutdown_prior} = 4'h0;
    {want, cfg_sp_value, meas_reactive, cfg_dwell} = '0;
    cfg_mode = EMSP_VREG;
    cfg_vl_assign = EMSP_VL_VARPF;
    cfg_droop = 7'h64;
    cfg_knee = 10'h1F4;
    cfg_slope = 9'h064;
    cfg_ov_level = 12'h44C;
    cfg_ov_delay = 7'h01;
    meas_freq = 10'h258;
    meas_gen_volt = 12'h3E8;
    cyc(19);
    chk({15'h0, alarm_relay_contact}, 16'h0000);
    @(posedge mclk);
    rst <= 1'b0;
    cyc(3);
    chk({15'h0, alarm_relay_contact}, 16'h0001);
    foreach (mrow[i]) begin
      @(posedge mclk);
      cfg_mode <= emsp_mode_t'(mrow[i][11:10]);
      cfg_vl_assign <= emsp_vl_assign_t'(mrow[i][9:8]);
      set_contacts({2'b00, mrow[i][7:5]});
      chk({14'h0, mode_active}, {14'h0, mrow[i][4:3]});
      chk({15'h0, droop_active}, {15'h0, mrow[i][2]});
      chk({15'h0, vpf_lamp}, {15'h0, mrow[i][1]});
      chk({15'h0, vmatch_active}, {15'h0, mrow[i][0]});
    end
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk);
      cfg_vl_assign <= EMSP_VL_LIMIT;
      set_contacts({2'b00, v[0], 2'b10});
      chk({15'h0, limiter_sel_exc}, {15'h0, v[0]});
    end
    chk({14'h0, exc_limiter_avail, second_oel_avail}, 16'h0003);
    @(posedge mclk);
    cfg_vl_assign <= EMSP_VL_VARPF;
    set_contacts(5'h00);
    chk({14'h0, exc_limiter_avail, second_oel_avail}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      cfg_mode <= lmode[i];
      cyc(3);
      cfg_sp_load <= 1'b1;
      cfg_sp_value <= lval[i];
      @(posedge mclk);
      cfg_sp_load <= 1'b0;
      cyc(3);
      chk({4'h0, active_setpoint}, {4'h0, lexp[i]});
    end
    @(posedge mclk);
    set_contacts(5'h10);
    cyc(930);
    chk({4'h0, active_setpoint}, {4'h0, FCR_MAX});
    @(posedge mclk);
    want <= 5'h00;
    wait_sig(1'b0, 1'b1, 9000, n);
    chk({15'h0, n >= 8000 && n <= 8100}, 16'h0001);
    chk({2'b00, saved_mode, saved_setpoint}, {2'b00, EMSP_FCR, FCR_MAX});
    @(posedge mclk);
    cfg_mode <= EMSP_VREG;
    cfg_vl_assign <= EMSP_VL_NONE;
    meas_reactive <= 12'h3E8;
    cyc(10);
    chk({15'h0, volt_setpoint_eff < VREG_MAX}, 16'h0001);
    @(posedge mclk);
    meas_reactive <= 12'hC18;
    cyc(10);
    chk({15'h0, volt_setpoint_eff > VREG_MAX}, 16'h0001);
    @(posedge mclk);
    meas_reactive <= 12'h000;
    cfg_slope <= 9'h000;
    meas_freq <= 10'h1C2;
    cyc(10);
    chk({15'h0, uf_lamp}, 16'h0000);
    @(posedge mclk);
    cfg_slope <= 9'h064;
    cyc(10);
    chk({14'h0, uf_lamp, volt_setpoint_eff < VREG_MAX}, 16'h0003);
    @(posedge mclk);
    cfg_slope <= SLOPE_MAX;
    meas_freq <= 10'h082;
    cyc(10);
    chk({4'h0, volt_setpoint_eff}, 16'h014A);
    @(posedge mclk);
    meas_freq <= 10'h064;
    cyc(10);
    chk({3'h0, uf_lamp, volt_setpoint_eff}, {4'h0, VREG_MAX});
    @(posedge mclk);
    meas_freq <= 10'h258;
    ext_alarm <= 1'b1;
    cyc(3);
    chk({15'h0, alarm_relay_contact}, 16'h0000);
    @(posedge mclk);
    ext_alarm <= 1'b0;
    cfg_ov_level <= 12'h514;
    meas_gen_volt <= OV_LVL_MAX;
    cyc(600);
    chk({14'h0, ov_lamp, alarm_relay_contact}, 16'h0001);
    for (int d = 0; d < 2; d++) begin
      @(posedge mclk);
      cfg_ov_act_disable <= d[0];
      meas_gen_volt <= OV_LVL_MAX + 12'h001;
      wait_sig(1'b1, 1'b1, 800, n);
      chk({15'h0, n >= 395 && n <= 410}, 16'h0001);
      chk({15'h0, alarm_relay_contact}, 16'h0000);
      @(posedge mclk);
      meas_gen_volt <= 12'h3E8;
      cyc(3);
      chk({14'h0, ov_lamp, ov_shutdown}, {15'h0, d[0]});
      if (d == 0) chk({15'h0, alarm_relay_contact}, 16'h0001);
    end
    @(posedge mclk);
    rst <= 1'b1;
    ov_shutdown_prior <= 1'b1;
    cyc(20);
    rst <= 1'b0;
    wait_sig(1'b1, 1'b1, 5, n);
    wait_sig(1'b1, 1'b0, 21000, n);
    chk({15'h0, n >= 19990 && n <= 20010}, 16'h0001);
    chk({15'h0, ov_shutdown}, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
